// >>> rtl/oag_pkg.sv
// Package holding constants and types for the operand address generator.
package oag_pkg;

   // Address modes as presented by the instruction decoder.
   typedef enum logic [3:0] {
      OAG_PAGE_ZERO = 4'h0,
      OAG_FULL_ADDRESS = 4'h1,
      OAG_INDEX_PLAIN = 4'h2,
      OAG_INDEX_POST_INC = 4'h3,
      OAG_INDEX_SHORT = 4'h4,
      OAG_INDEX_SHORT_POST_INC = 4'h5,
      OAG_INDEX_LONG = 4'h6,
      OAG_STACK_SHORT = 4'h7,
      OAG_STACK_LONG = 4'h8
   } oag_mode_t;

   // Instruction classes that matter for mode legality.
   typedef enum logic [1:0] {
      OAG_CLASS_OTHER = 2'h0,
      OAG_CLASS_CMP_BRANCH = 2'h1,
      OAG_CLASS_MOVE = 2'h2
   } oag_class_t;

   // Reset value of the stack pointer: top of the page-zero space.
   localparam logic [15:0] OAG_SP_RESET = 16'h00FF;
   // Reset value of the index pair.
   localparam logic [15:0] OAG_INDEX_RESET = 16'h0000;
   // High byte forced in page-zero mode.
   localparam logic [7:0] OAG_PAGE_ZERO_HIGH = 8'h00;
   // Step applied by post-increment modes.
   localparam logic [15:0] OAG_INC_STEP = 16'h0001;
   // Operand bytes that follow the opcode, per mode.
   localparam logic [1:0] OAG_BYTES_NONE = 2'h0;
   localparam logic [1:0] OAG_BYTES_ONE = 2'h1;
   localparam logic [1:0] OAG_BYTES_TWO = 2'h2;

endpackage

// >>> rtl/oag_adder.sv
// Sixteen-bit wrapping adder used to form effective addresses.
`timescale 1ns/1ps
module oag_adder (
   input wire logic [15:0] base,
   input wire logic [15:0] offset,
   output logic [15:0] sum
);
   // Carry out is discarded on purpose so the result wraps modulo 65536.
   logic [16:0] full_sum;
   assign full_sum = {1'b0, base} + {1'b0, offset};
   assign sum = full_sum[15:0];
endmodule

// >>> rtl/oag_top.sv
// Operand effective-address generator with index pair and stack pointer.
`timescale 1ns/1ps
module oag_top (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic req_valid,
   output logic req_ready,
   input wire oag_pkg::oag_mode_t req_mode,
   input wire oag_pkg::oag_class_t req_class,
   input wire logic [7:0] operand_hi,
   input wire logic [7:0] operand_lo,
   input wire logic index_load,
   input wire logic [15:0] index_load_value,
   input wire logic sp_load,
   input wire logic [15:0] sp_load_value,
   input wire logic bus_done,
   output logic [15:0] bus_addr,
   output logic bus_valid,
   output logic [1:0] operand_bytes,
   output logic mode_illegal,
   output logic [15:0] index_pair,
   output logic [15:0] stack_pointer
);
   import oag_pkg::*;

   // One-hot sequencer: idle, address on bus, post-access update.
   typedef enum logic [2:0] {
      OAG_ST_IDLE = 3'b001,
      OAG_ST_ACCESS = 3'b010,
      OAG_ST_UPDATE = 3'b100
   } oag_state_t;

   oag_state_t state_reg;
   oag_state_t state_next;
   logic [15:0] index_reg; // Index pair.
   logic [15:0] sp_reg; // Stack pointer, next free slot.
   logic [15:0] addr_reg; // Latched effective address.
   logic [1:0] bytes_reg; // Operand byte count of the accepted mode.
   logic illegal_reg; // Last request used a mode the opcode lacks.
   logic post_inc_reg; // Accepted mode increments the index pair.
   logic [15:0] base_sel; // Adder base.
   logic [15:0] offset_sel; // Adder offset.
   logic [15:0] ea_sum; // Adder result.
   logic [15:0] index_inc; // Index pair plus one.
   logic [15:0] ea_next; // Effective address for this request.
   logic [1:0] bytes_next; // Byte count for this request.
   logic legal_next; // Mode allowed for this instruction class.
   logic post_inc_next; // Mode is a post-increment form.
   logic accept; // Request taken this cycle.

   // Zero-extends a single operand byte into a 16-bit offset.
   function automatic logic [15:0] oag_zext8(input logic [7:0] b);
      return {8'h00, b};
   endfunction

   // Ready is decoded from the state register alone, so it never depends on
   // req_valid and cannot form a combinational loop with the requester.
   assign req_ready = (state_reg == OAG_ST_IDLE);
   // A request is taken only on an edge where both sides agree.
   assign accept = req_valid && req_ready;

   // Shared adder for every offset mode; both offsets are unsigned.
   oag_adder u_adder (
      .base(base_sel),
      .offset(offset_sel),
      .sum(ea_sum)
   );

   // Same adder type forms the post-increment value, wrapping at the top.
   oag_adder u_inc (
      .base(index_reg),
      .offset(OAG_INC_STEP),
      .sum(index_inc)
   );

   // Mode decode: picks base, offset, byte count and legality.
   always_comb begin
      base_sel = index_reg;
      offset_sel = 16'h0000;
      ea_next = 16'h0000;
      bytes_next = OAG_BYTES_NONE;
      legal_next = 1'b1;
      post_inc_next = 1'b0;
      unique case (req_mode)
         OAG_PAGE_ZERO: begin
            // High byte is implied, so only one operand byte is fetched.
            ea_next = {OAG_PAGE_ZERO_HIGH, operand_lo};
            bytes_next = OAG_BYTES_ONE;
         end
         OAG_FULL_ADDRESS: begin
            ea_next = {operand_hi, operand_lo};
            bytes_next = OAG_BYTES_TWO;
         end
         OAG_INDEX_PLAIN: begin
            ea_next = index_reg;
         end
         OAG_INDEX_POST_INC: begin
            ea_next = index_reg;
            post_inc_next = 1'b1;
            // Only the two listed classes may use it; any other code is refused.
            legal_next = (req_class == OAG_CLASS_CMP_BRANCH) ||
               (req_class == OAG_CLASS_MOVE);
         end
         OAG_INDEX_SHORT: begin
            offset_sel = oag_zext8(operand_lo);
            ea_next = ea_sum;
            bytes_next = OAG_BYTES_ONE;
         end
         OAG_INDEX_SHORT_POST_INC: begin
            offset_sel = oag_zext8(operand_lo);
            ea_next = ea_sum;
            bytes_next = OAG_BYTES_ONE;
            post_inc_next = 1'b1;
            legal_next = (req_class == OAG_CLASS_CMP_BRANCH);
         end
         OAG_INDEX_LONG: begin
            offset_sel = {operand_hi, operand_lo};
            ea_next = ea_sum;
            bytes_next = OAG_BYTES_TWO;
         end
         OAG_STACK_SHORT: begin
            // Zero offset lands on the free slot, not the last pushed byte.
            base_sel = sp_reg;
            offset_sel = oag_zext8(operand_lo);
            ea_next = ea_sum;
            bytes_next = OAG_BYTES_ONE;
         end
         OAG_STACK_LONG: begin
            base_sel = sp_reg;
            offset_sel = {operand_hi, operand_lo};
            ea_next = ea_sum;
            bytes_next = OAG_BYTES_TWO;
         end
         default: begin
            // Undefined mode codes are flagged and produce no access.
            legal_next = 1'b0;
         end
      endcase
   end

   // Next-state logic; an illegal mode is refused without a bus access.
   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         OAG_ST_IDLE: begin
            if (accept && legal_next) begin
               state_next = OAG_ST_ACCESS;
            end
         end
         OAG_ST_ACCESS: begin
            // The address stands until the memory side ends the access.
            if (bus_done) begin
               state_next = post_inc_reg ? OAG_ST_UPDATE : OAG_ST_IDLE;
            end
         end
         OAG_ST_UPDATE: begin
            // One extra cycle in which the pair takes its incremented value.
            state_next = OAG_ST_IDLE;
         end
         default: begin
            state_next = OAG_ST_IDLE;
         end
      endcase
   end

   // State register.
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         state_reg <= OAG_ST_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   // Capture of the effective address and request attributes.
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         addr_reg <= 16'h0000;
         bytes_reg <= OAG_BYTES_NONE;
         illegal_reg <= 1'b0;
         post_inc_reg <= 1'b0;
      end else if (accept) begin
         // Refused requests latch too, so the outputs always describe the last
         // request; mode_illegal tells the fetch side to discard the address.
         addr_reg <= ea_next;
         bytes_reg <= bytes_next;
         illegal_reg <= !legal_next;
         post_inc_reg <= post_inc_next && legal_next;
      end
   end

   // Index pair: the increment happens only after the operand access ends,
   // so the address used is always the pre-increment value. Offset modes other
   // than the short post-increment form never write here, keeping the pair untouched.
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         index_reg <= OAG_INDEX_RESET;
      end else if (state_reg == OAG_ST_UPDATE) begin
         index_reg <= index_inc;
      end else if (index_load && req_ready) begin
         // External loads are held off during an access to keep it stable.
         index_reg <= index_load_value;
      end
   end

   // Stack pointer: reset value is the top of page zero; software moves it.
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         sp_reg <= OAG_SP_RESET;
      end else if (sp_load && req_ready) begin
         sp_reg <= sp_load_value;
      end
   end

   // Data outputs come straight from registers; bus_valid is a decode of the
   // one-hot state and so changes only at clock edges.
   assign bus_addr = addr_reg;
   assign bus_valid = (state_reg == OAG_ST_ACCESS);
   assign operand_bytes = bytes_reg;
   assign mode_illegal = illegal_reg;
   assign index_pair = index_reg;
   assign stack_pointer = sp_reg;

endmodule

// >>> sim/oag_mem_model.sv
// Memory bus partner that ends each access after a set wait.
`timescale 1ns/1ps
module oag_mem_model (
   input wire logic clock,
   input wire logic bus_valid,
   input wire logic [3:0] wait_cycles,
   output logic bus_done
);
   // Cycles spent on the pending access.
   logic [3:0] busy_count = 4'h0;
   // Answer pulse, kept in one variable so that it has a single driver.
   logic done_reg = 1'b0;
   // Driven on the falling edge so the pulse is steady at the sampling edge.
   always @(negedge clock) begin
      done_reg <= bus_valid && !done_reg && busy_count == wait_cycles;
      busy_count <= bus_valid ? busy_count + 4'h1 : 4'h0;
   end
   assign bus_done = done_reg;
endmodule

// >>> sim/oag_sva.sv
// Port assertions for the operand address generator.
`timescale 1ns/1ps
module oag_sva (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic req_valid,
   input wire logic req_ready,
   input wire oag_pkg::oag_mode_t req_mode,
   input wire oag_pkg::oag_class_t req_class,
   input wire logic [7:0] operand_hi,
   input wire logic [7:0] operand_lo,
   input wire logic [15:0] bus_addr,
   input wire logic bus_valid,
   input wire logic [1:0] operand_bytes,
   input wire logic mode_illegal,
   input wire logic [15:0] index_pair,
   input wire logic [15:0] stack_pointer
);
   import oag_pkg::*;
   wire a = req_valid && req_ready;
   wire [3:0] m = req_mode;
   wire [15:0] o8 = {8'h00, operand_lo};
   wire [15:0] o16 = {operand_hi, operand_lo};
   // Post-increment that its instruction class permits.
   wire pi = m == 4'h3 && (req_class == OAG_CLASS_CMP_BRANCH || req_class == OAG_CLASS_MOVE)
      || m == 4'h5 && req_class == OAG_CLASS_CMP_BRANCH;
   logic [15:0] idx_due;
   always_ff @(posedge clock) if (a) idx_due <= index_pair + OAG_INC_STEP;
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_b);
   a_page_zero: assert property (
      a && m == 4'h0 |=> bus_addr == $past(o8) && operand_bytes == 2'h1)
      else $error("page zero");
   a_full_addr: assert property (
      a && m == 4'h1 |=> bus_addr == $past(o16) && operand_bytes == 2'h2)
      else $error("full address");
   a_index_plain: assert property (
      a && (m == 4'h2 || pi && m == 4'h3) |=> bus_addr == $past(index_pair))
      else $error("plain index");
   a_index_short: assert property (
      a && (m == 4'h4 || pi && m == 4'h5) |=> bus_addr == $past(index_pair) + $past(o8))
      else $error("short index");
   a_index_long: assert property (
      a && m == 4'h6 |=> bus_addr == $past(index_pair) + $past(o16) ##1 $stable(index_pair))
      else $error("long index");
   a_stack_short: assert property (
      a && m == 4'h7 |=> bus_addr == $past(stack_pointer) + $past(o8))
      else $error("short stack");
   a_stack_long: assert property (
      a && m == 4'h8 |=> bus_addr == $past(stack_pointer) + $past(o16) ##1 $stable(stack_pointer))
      else $error("long stack");
   a_post_inc: assert property (
      a && pi |-> ##[2:40] req_ready && index_pair == idx_due) else $error("post increment");
   a_mode_refused: assert property (
      a && !pi && (m == 4'h3 || m == 4'h5) |=> mode_illegal && !bus_valid)
      else $error("refused mode");
endmodule

// >>> sim/tb.sv
// Random bench for the operand address generator.
`timescale 1ns/1ps
module tb;
   import oag_pkg::*;
   logic clock, rst_b, req_valid, index_load, sp_load, bad, inc, chain;
   oag_mode_t req_mode;
   oag_class_t req_class;
   logic [7:0] operand_hi, operand_lo;
   logic [3:0] wait_cycles;
   logic [15:0] index_load_value, sp_load_value, ea;
   wire req_ready, bus_done, bus_valid, mode_illegal;
   wire [1:0] operand_bytes;
   wire [15:0] bus_addr, index_pair, stack_pointer;
   integer seed = 32'hc9f2, n_fail = 0, cmp_count = 0, i, k = 0;
   oag_top DUT (
      .clock(clock),
      .rst_b(rst_b),
      .req_valid(req_valid),
      .req_ready(req_ready),
      .req_mode(req_mode),
      .req_class(req_class),
      .operand_hi(operand_hi),
      .operand_lo(operand_lo),
      .index_load(index_load),
      .index_load_value(index_load_value),
      .sp_load(sp_load),
      .sp_load_value(sp_load_value),
      .bus_done(bus_done),
      .bus_addr(bus_addr),
      .bus_valid(bus_valid),
      .operand_bytes(operand_bytes),
      .mode_illegal(mode_illegal),
      .index_pair(index_pair),
      .stack_pointer(stack_pointer)
   );
   oag_mem_model MEM (
      .clock(clock),
      .bus_valid(bus_valid),
      .wait_cycles(wait_cycles),
      .bus_done(bus_done)
   );
   task chk(input string n, input logic [15:0] s, e);
      cmp_count++;
      if (s !== e) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask
   task report_and_stop;
      $display("checks %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // Expected effective address from mode, pair, stack pointer and operand bytes.
   function automatic logic [15:0] exp_addr(input logic [3:0] mode, input logic [15:0] idx,
         input logic [15:0] stk, input logic [15:0] opnd);
      case (mode)
         4'h0: return {8'h00, opnd[7:0]};
         4'h1: return opnd;
         4'h2, 4'h3: return idx;
         4'h4, 4'h5: return idx + {8'h00, opnd[7:0]};
         4'h6: return idx + opnd;
         4'h7: return stk + {8'h00, opnd[7:0]};
         default: return stk + opnd;
      endcase
   endfunction
   // Operand bytes that follow the opcode for each mode; undefined codes have none.
   function automatic logic [1:0] exp_bytes(input logic [3:0] mode);
      case (mode)
         4'h0, 4'h4, 4'h5, 4'h7: return OAG_BYTES_ONE;
         4'h1, 4'h6, 4'h8: return OAG_BYTES_TWO;
         default: return OAG_BYTES_NONE;
      endcase
   endfunction
   // Load both registers unless chaining on the previous request, request right
   // behind the load, then check.
   task op;
      {index_load, sp_load} = chain ? 2'h0 : 2'h3;
      @(negedge clock);
      {index_load, sp_load, req_valid} = 3'h1;
      @(negedge clock);
      req_valid = 1'b0;
      chk("flags", {14'h0, bus_valid, mode_illegal}, {14'h0, !bad, bad});
      chk("bytes", {14'h0, operand_bytes}, {14'h0, exp_bytes(req_mode)});
      if (!bad)
         chk("address", bus_addr, ea);
      for (k = 0; k < 40 && req_ready !== 1'b1; k++)
         @(negedge clock);
      if (k == 40) begin
         // A hang counts once; the main loop then stops and the second reset test runs before the report.
         n_fail++;
      end else begin
         chk("index", index_pair, index_load_value + {15'h0, inc});
         chk("stack", stack_pointer, sp_load_value);
      end
   endtask
   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end
   initial begin
      {rst_b, req_valid, index_load, sp_load, operand_hi, operand_lo, wait_cycles} = '0;
      {index_load_value, sp_load_value} = '0;
      req_mode = OAG_PAGE_ZERO;
      req_class = OAG_CLASS_OTHER;
      repeat (2) @(negedge clock);
      rst_b = 1'b1;
      chk("reset stack", stack_pointer, OAG_SP_RESET);
      $display("test reset done");
      // Every mode first at the wrap corner, then random traffic.
      for (i = 0; i < 300 && k != 40; i++) begin
         req_mode = oag_mode_t'(i < 18 ? i % 9 : {$random(seed)} % 11);
         req_class = oag_class_t'(i < 18 ? 1 : {$random(seed)} % 3);
         {operand_hi, operand_lo} = i < 9 ? 16'hFFFF : i < 18 ? 16'h0 : 16'($random(seed));
         // Every fourth random request reuses the pair and stack pointer that the
         // previous one left, so a fresh increment must be used at once.
         chain = i >= 18 && i % 4 == 3;
         if (chain) begin
            index_load_value = index_load_value + {15'h0, inc};
         end else begin
            index_load_value = i < 18 ? 16'hFFFF : 16'($random(seed));
            sp_load_value = 16'($random(seed));
         end
         wait_cycles = i % 7 == 0 ? 4'h9 : 4'({$random(seed)} % 3);
         bad = req_mode > 4'h8 || req_mode == 4'h3 && req_class == OAG_CLASS_OTHER
            || req_mode == 4'h5 && req_class != OAG_CLASS_CMP_BRANCH;
         inc = req_mode inside {4'h3, 4'h5} && !bad;
         ea = exp_addr(req_mode, index_load_value, sp_load_value, {operand_hi, operand_lo});
         op();
      end
      $display("test random done");
      // Reset again in mid-run; the stack pointer must fall back to its reset value.
      rst_b = 1'b0;
      repeat (2) @(negedge clock);
      rst_b = 1'b1;
      chk("second reset stack", stack_pointer, OAG_SP_RESET);
      $display("test second reset done");
      report_and_stop();
   end
endmodule
bind oag_top oag_sva u_sva (
   .clock(clock),
   .rst_b(rst_b),
   .req_valid(req_valid),
   .req_ready(req_ready),
   .req_mode(req_mode),
   .req_class(req_class),
   .operand_hi(operand_hi),
   .operand_lo(operand_lo),
   .bus_addr(bus_addr),
   .bus_valid(bus_valid),
   .operand_bytes(operand_bytes),
   .mode_illegal(mode_illegal),
   .index_pair(index_pair),
   .stack_pointer(stack_pointer)
);
